// [hw/wss_defines.vh]
// Register offsets, field positions and reset values of the waveform steering and shutdown stage
`ifndef WSS_DEFINES_VH
`define WSS_DEFINES_VH
`define WSS_OFF_CTRL0 12'h000
`define WSS_OFF_CTRL1 12'h004
`define WSS_OFF_STEER 12'h008
`define WSS_OFF_SDC0 12'h00c
`define WSS_OFF_SDSRC 12'h010
`define WSS_OFF_DBR 12'h014
`define WSS_OFF_DBF 12'h018
`define WSS_OFF_CLKSEL 12'h01c
`define WSS_EN_BIT 7
`define WSS_LD_BIT 6
`define WSS_SD_BIT 7
`define WSS_REN_BIT 6
`define WSS_RST_CTRL0 8'h00
`define WSS_RST_SDC0 8'h14
`define WSS_MODE_STEER 3'h0
`define WSS_MODE_SSTEER 3'h1
`define WSS_MODE_FFB 3'h2
`define WSS_MODE_RFB 3'h3
`define WSS_MODE_HB 3'h4
`define WSS_MODE_PP 3'h5
`define WSS_OVR_ONE 2'h3
`define WSS_OVR_ZERO 2'h2
`define WSS_OVR_TRI 2'h1
`define WSS_OVR_INACT 2'h0
`endif

// [hw/wss_top.v]
// Steering, polarity, auto-shutdown and restart stage with its APB registers
//
// The placing of the registers and the APB register port are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "wss_defines.vh"
module wss_top #(
	parameter DBW = 6
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	input wire input_data,
	input wire comparator_one_out,
	input wire comparator_two_out,
	input wire timer_two_post_out,
	input wire shutdown_pin_input,
	input wire sleep_active,
	output wire [3:0] waveform_out,
	output wire [3:0] waveform_oe_n,
	output wire internal_fast_oscillator_req,
	output wire [DBW-1:0] rise_deadband_active,
	output wire [DBW-1:0] fall_deadband_active,
	output wire [2:0] mode_out,
	output wire enable_out
);
	// ==========================================
	// Registers
	reg [2:0] mode_q;
	reg en_q;
	reg ld_q;
	reg [3:0] pol_q;
	reg [3:0] steer_q;
	reg [3:0] steer_act_q;
	reg sd_q;
	reg ren_q;
	reg [1:0] ovr_bd_q;
	reg [1:0] ovr_ac_q;
	reg [3:0] src_en_q;
	reg [DBW-1:0] dbr_q;
	reg [DBW-1:0] dbf_q;
	reg [DBW-1:0] dbr_act_q;
	reg [DBW-1:0] dbf_act_q;
	reg clk_sel_q;
	reg in_q;
	reg hold_q;

	wire wr = psel & penable & pwrite;
	wire rise = input_data & ~in_q;
	wire fall = ~input_data & in_q;
	wire steer_mode = (mode_q == `WSS_MODE_STEER) | (mode_q == `WSS_MODE_SSTEER);
	// Sources are active low; invert so a one means a fault request
	wire [3:0] src_act = ~{shutdown_pin_input, timer_two_post_out, comparator_two_out,
		comparator_one_out} & src_en_q;
	wire any_src = |src_act;
	// Asynchronous path so a fault needs no clock edge to reach the pins
	wire shutdown = sd_q | any_src | hold_q;

	assign pready = 1'b1;
	assign pslverr = 1'b0;
	assign mode_out = mode_q;
	assign enable_out = en_q;
	assign rise_deadband_active = dbr_act_q;
	assign fall_deadband_active = dbf_act_q;
	assign internal_fast_oscillator_req = en_q & clk_sel_q & (input_data | in_q | ~sleep_active);

	function sel_wr;
		input [11:0] a;
		input [11:0] off;
		sel_wr = (a == off);
	endfunction

	// ==========================================
	// Register writes and flag control
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_q <= 3'h0;
			en_q <= 1'b0;
			ld_q <= 1'b0;
			pol_q <= 4'h0;
			steer_q <= 4'h0;
			steer_act_q <= 4'h0;
			sd_q <= 1'b0;
			ren_q <= 1'b0;
			ovr_bd_q <= 2'h1;
			ovr_ac_q <= 2'h1;
			src_en_q <= 4'h0;
			dbr_q <= {DBW{1'b0}};
			dbf_q <= {DBW{1'b0}};
			dbr_act_q <= {DBW{1'b0}};
			dbf_act_q <= {DBW{1'b0}};
			clk_sel_q <= 1'b0;
			in_q <= 1'b0;
			hold_q <= 1'b0;
		end else begin
			in_q <= input_data;
			if (wr && sel_wr(paddr, `WSS_OFF_CTRL0)) begin
				mode_q <= pwdata[2:0];
				en_q <= pwdata[`WSS_EN_BIT];
				// Load request only accepted once already enabled
				ld_q <= pwdata[`WSS_LD_BIT] & en_q;
			end else if (ld_q && (rise || fall)) begin
				ld_q <= 1'b0;
			end
			if (wr && sel_wr(paddr, `WSS_OFF_CTRL1))
				pol_q <= pwdata[3:0];
			if (wr && sel_wr(paddr, `WSS_OFF_STEER))
				steer_q <= pwdata[3:0];
			if (wr && sel_wr(paddr, `WSS_OFF_SDSRC))
				src_en_q <= pwdata[3:0];
			if (wr && sel_wr(paddr, `WSS_OFF_CLKSEL))
				clk_sel_q <= pwdata[0];
			if (wr && sel_wr(paddr, `WSS_OFF_DBR))
				dbr_q <= pwdata[DBW-1:0];
			if (wr && sel_wr(paddr, `WSS_OFF_DBF))
				dbf_q <= pwdata[DBW-1:0];
			// Disabled: dead-band loads at once; enabled: on request at an input edge
			if (!en_q || (ld_q && (rise || fall))) begin
				dbr_act_q <= dbr_q;
				dbf_act_q <= dbf_q;
			end
			// Steering applies immediately in 000, on input rise in 001
			if (mode_q == `WSS_MODE_SSTEER) begin
				if (rise)
					steer_act_q <= steer_q;
			end else begin
				// A steering write lands at its own edge, so no extra cycle of the old routing
				steer_act_q <= (wr && sel_wr(paddr, `WSS_OFF_STEER)) ? pwdata[3:0] : steer_q;
			end
			if (wr && sel_wr(paddr, `WSS_OFF_SDC0)) begin
				ren_q <= pwdata[`WSS_REN_BIT];
				ovr_bd_q <= pwdata[5:4];
				ovr_ac_q <= pwdata[3:2];
			end
			// Hardware set beats any clear in the same cycle
			if (any_src) begin
				sd_q <= 1'b1;
			end else if (wr && sel_wr(paddr, `WSS_OFF_SDC0) && pwdata[`WSS_SD_BIT]) begin
				sd_q <= 1'b1;
			end else if (ren_q) begin
				sd_q <= 1'b0;
			end else if (wr && sel_wr(paddr, `WSS_OFF_SDC0)) begin
				sd_q <= 1'b0;
			end
			// Overrides persist after flag clears until next rising input
			if (sd_q || any_src)
				hold_q <= 1'b1;
			else if (rise)
				hold_q <= 1'b0;
		end
	end

	// ==========================================
	// Output stage
	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : g_out
			wire [1:0] ovr = (g == 0 || g == 2) ? ovr_ac_q : ovr_bd_q;
			wire steered = steer_mode ? steer_act_q[g] : 1'b1;
			// Polarity inverts when set; fixed level is zero and ignores polarity
			wire norm = steered ? (input_data ^ pol_q[g]) : 1'b0;
			wire inact = pol_q[g];
			wire ovr_on = shutdown & en_q & steered;
			reg lvl;
			reg oe;
			always @* begin
				lvl = norm;
				oe = ~en_q;
				if (ovr_on || (shutdown && !en_q)) begin
					case (ovr)
						`WSS_OVR_ONE: begin
							lvl = 1'b1;
							oe = 1'b0;
						end
						`WSS_OVR_ZERO: begin
							lvl = 1'b0;
							oe = 1'b0;
						end
						`WSS_OVR_TRI: begin
							lvl = 1'b0;
							oe = 1'b1;
						end
						default: begin
							lvl = inact;
							oe = 1'b0;
						end
					endcase
				end else if (!en_q) begin
					lvl = 1'b0;
				end else begin
					oe = 1'b0;
				end
			end
			assign waveform_out[g] = lvl;
			assign waveform_oe_n[g] = oe;
		end
	endgenerate

	// ==========================================
	// Read mux
	always @* begin
		prdata = 32'h0;
		if (paddr == `WSS_OFF_CTRL0)
			prdata[7:0] = {en_q, ld_q, 3'h0, mode_q};
		else if (paddr == `WSS_OFF_CTRL1)
			prdata[7:0] = {2'h0, input_data, 1'b0, pol_q};
		else if (paddr == `WSS_OFF_STEER)
			prdata[3:0] = steer_q;
		else if (paddr == `WSS_OFF_SDC0)
			prdata[7:0] = {sd_q, ren_q, ovr_bd_q, ovr_ac_q, 2'h0};
		else if (paddr == `WSS_OFF_SDSRC)
			prdata[3:0] = src_en_q;
		else if (paddr == `WSS_OFF_DBR)
			prdata[DBW-1:0] = dbr_q;
		else if (paddr == `WSS_OFF_DBF)
			prdata[DBW-1:0] = dbf_q;
		else if (paddr == `WSS_OFF_CLKSEL)
			prdata[0] = clk_sel_q;
	end
endmodule // wss_top
`default_nettype wire

// [test/waveform_steering_shutdown_tb.sv]
// Bench for the steering and shutdown stage
`timescale 1ns/10ps
`default_nettype none
module waveform_steering_shutdown_tb;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic input_data = 1'b1, comparator_one_out = 1'b1, sleep_active = 1'b0;
	logic comparator_two_out = 1'b1, timer_two_post_out = 1'b1, shutdown_pin_input = 1'b1;
	wire logic [31:0] prdata;
	wire logic [3:0] waveform_out, waveform_oe_n, pins;
	wire logic [2:0] mode_out;
	wire logic [5:0] dbr_act;
	wire logic pready, internal_fast_oscillator_req, enable_out;
	int errors = 0;
	int checks_done = 0;
	logic [2:0] md [3] = '{3'h0, 3'h4, 3'h4};
	logic [7:0] sc [3] = '{8'h3c, 8'h2c, 8'h34};
	logic [7:0] ov [3] = '{8'h05, 8'h05, 8'h5a};
	wss_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr(),
		.input_data, .comparator_one_out, .comparator_two_out, .timer_two_post_out, .shutdown_pin_input,
		.sleep_active, .waveform_out, .waveform_oe_n, .internal_fast_oscillator_req,
		.rise_deadband_active(dbr_act), .fall_deadband_active(), .mode_out, .enable_out);
	wss_pin_model drv (.waveform_out, .waveform_oe_n, .pin(pins));
	// ==========================================
	// Tasks
	task automatic end_sim;
		$display("checks %0d mismatches %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Waits on pready, and gives up after 16 cycles without it
	task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d, output logic [31:0] q);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		q = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 16) begin
			errors++;
			end_sim;
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic rdc(input logic [11:0] a, input logic [7:0] e);
		logic [31:0] q;
		bus(1'b0, a, 8'h00, q);
		chk(q, {24'h0, e});
	endtask
	task automatic pc(input logic [7:0] e);
		#1 chk({24'h0, waveform_oe_n, pins}, {24'h0, e});
	endtask
	task automatic tick(input logic v);
		@(posedge pclk);
		input_data <= v;
		@(posedge pclk);
	endtask
	// ==========================================
	// Sequence
	initial begin
		forever #12.5 pclk = ~pclk;
	end
	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rdc(12'h00c, 8'h14);
		wr(12'h000, 8'h40);
		rdc(12'h000, 8'h00);
		wr(12'h004, 8'h00);
		wr(12'h008, 8'h05);
		wr(12'h01c, 8'h01);
		sleep_active <= 1'b1;
		for (int i = 0; i < 3; i++) begin
			wr(12'h010, 8'h01);
			wr(12'h00c, 8'h80 | sc[i]);
			wr(12'h000, {5'h10, md[i]});
			pc(ov[i]);
			chk({31'h0, internal_fast_oscillator_req}, 32'h1);
			wr(12'h00c, sc[i]);
			tick(1'b0);
			tick(1'b1);
			pc(md[i] == 3'h0 ? 8'h05 : 8'h0f);
			@(posedge pclk);
			comparator_one_out <= 1'b0;
			pc(ov[i]);
			wr(12'h00c, sc[i]);
			rdc(12'h00c, 8'h80 | sc[i]);
			comparator_one_out <= 1'b1;
			wr(12'h00c, sc[i]);
			pc(ov[i]);
			tick(1'b0);
			tick(1'b1);
			pc(md[i] == 3'h0 ? 8'h05 : 8'h0f);
			wr(12'h000, 8'h00);
			$display("shutdown case %0d done", i);
		end
		wr(12'h000, 8'h80);
		wr(12'h008, 8'h0f);
		pc(8'h0f);
		wr(12'h000, 8'h81);
		wr(12'h008, 8'h03);
		pc(8'h0f);
		tick(1'b0);
		tick(1'b1);
		pc(8'h03);
		wr(12'h004, 8'h05);
		pc(8'h02);
		$display("steering test done");
		wr(12'h014, 8'h2a);
		chk({26'h0, dbr_act}, 32'h0);
		wr(12'h000, 8'hc1);
		rdc(12'h000, 8'hc1);
		tick(1'b0);
		rdc(12'h000, 8'h81);
		chk({26'h0, dbr_act}, 32'h2a);
		$display("load request test done");
		end_sim;
	end
endmodule // waveform_steering_shutdown_tb
`default_nettype wire

// [test/wss_chk_sva.sv]
// Assertion checker for the steering and shutdown stage
`timescale 1ns/10ps
`default_nettype none
module wss_chk (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic comparator_one_out,
	input wire logic [3:0] waveform_out,
	input wire logic [3:0] waveform_oe_n,
	input wire logic internal_fast_oscillator_req,
	input wire logic [2:0] mode_out,
	input wire logic enable_out
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic src_q;
	logic [3:0] ovr_q;
	wire logic wr = psel && penable && pwrite;
	wire logic ctl_wr = wr && paddr == 12'h000;
	// Only source one is tracked; the others merely leave these idle
	wire logic hot = enable_out && mode_out[2:1] != 2'h0 && src_q && !comparator_one_out;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			src_q <= 1'b0;
			ovr_q <= 4'h5;
		end else if (wr && paddr == 12'h010) begin
			src_q <= pwdata[0];
		end else if (wr && paddr == 12'h00c) begin
			ovr_q <= pwdata[5:2];
		end
	end
	sequence s_held;
		hot ##1 hot && psel && paddr == 12'h00c;
	endsequence
	a_mode_load: assert property (ctl_wr |=> mode_out == $past(pwdata[2:0]))
		else $error("mode not loaded");
	a_en_load: assert property (ctl_wr |=> enable_out == $past(pwdata[7]))
		else $error("enable not loaded");
	a_en_cause: assert property (!$stable(enable_out) |-> $past(ctl_wr))
		else $error("enable moved alone");
	a_flag_held: assert property (s_held |-> prdata[7])
		else $error("flag not held");
	a_ac_one: assert property (hot && ovr_q[1:0] == 2'h3 |-> waveform_out[0] && waveform_out[2])
		else $error("ac not one");
	a_ac_tri: assert property (hot && ovr_q[1:0] == 2'h1 |-> waveform_oe_n[0] && waveform_oe_n[2])
		else $error("ac not released");
	a_bd_zero: assert property (hot && ovr_q[3:2] == 2'h2 |-> (waveform_out[3:1] & 3'h5) == 3'h0)
		else $error("bd not zero");
	a_osc_en: assert property (internal_fast_oscillator_req |-> enable_out)
		else $error("osc kept while off");
endmodule // wss_chk
bind wss_top wss_chk chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
	.comparator_one_out, .waveform_out, .waveform_oe_n, .internal_fast_oscillator_req, .mode_out, .enable_out);
`default_nettype wire

// [test/wss_pin_model.sv]
// Gate driver inputs at the far side of the four outputs
`timescale 1ns/10ps
`default_nettype none
module wss_pin_model (
	input wire logic [3:0] waveform_out,
	input wire logic [3:0] waveform_oe_n,
	output logic [3:0] pin
);
	// Driver inputs carry pull-downs, so a released pin reads low
	assign pin = waveform_out & ~waveform_oe_n;
endmodule // wss_pin_model
`default_nettype wire
